// ==== ftct_pkg.sv ====
// Operation
// - Full failure detection in normal mode
// - Failure counts only after qualifying delay
// - Return to differential after recovery delay
// - Failures 1,2,4,6a keep differential operation
// - Time dominant transmit input, stop driving
// - Dominant time-out between 0.75 and 4 ms
// - Failures 3,3a,5,6,6a,7 disable affected wire
// - Error output low while failure present in normal mode
// - Bus wake by either line dominant
// - Three low-power modes plus go-to-sleep
// - Sleep: inhibit floats, low line biased
// - Sleep: wake flag on receive and error
// - Standby like sleep, inhibit held high
// - Power-on standby shows power-on flag
// - Power-on flag set, cleared by normal
// - Wake on power-on, local, remote events
// - Local wake edge debounced 7 to 38 us
// - Wake request drives inhibit output high
// - Low-power modes keep partial failure detection
// - Go-to-sleep keeps inhibit for limited time
// - Logic supply loss forces mode inputs low
package ftct_pkg;

    localparam int unsigned CLK_PERIOD_PS    = 5000;
    localparam int unsigned DOM_TIMEOUT_NS   = 750000;
    localparam int unsigned WAKE_DEBOUNCE_NS = 7000;
    localparam int unsigned SLEEP_ENTRY_HOLD_TIME_NS = 5000;
    localparam int unsigned BIT_TIME_NS      = 8000;
    localparam int unsigned REMOTE_WAKE_BITS = 5;
    localparam int unsigned DOM_TIMEOUT_CYC  = (DOM_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned WAKE_DEBOUNCE_CYC = (WAKE_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1)
                                                / CLK_PERIOD_PS;
    localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_HOLD_TIME_NS * 1000
                                               + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REMOTE_WAKE_CYC = (REMOTE_WAKE_BITS * BIT_TIME_NS * 1000
                                               + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned FAIL_QUAL_CYC_DEF  = 1000;
    localparam int unsigned FAIL_RECOV_CYC_DEF = 2000;

    localparam int unsigned CNT_W  = 18;
    localparam int unsigned NFAIL  = 9;
    localparam int unsigned ADDR_W = 4;

    // Failure bit order: 1,2,3,3a,4,5,6,6a,7
    localparam logic [8:0] FAIL_H_MASK  = 9'h02c;
    localparam logic [8:0] FAIL_L_MASK  = 9'h1c0;
    localparam logic [8:0] FAIL_SW_MASK = 9'h16c;
    localparam logic [8:0] FAIL_LP_MASK = 9'h11c;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_FAIL   = 4'h8;
    localparam int unsigned CTRL_TX_MUTE   = 0;
    localparam int unsigned CTRL_WAKE_CLR  = 1;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        FT_NORMAL  = 3'h0,
        FT_GTS     = 3'h1,
        FT_SLEEP   = 3'h3,
        FT_STANDBY = 3'h2,
        FT_PWRON   = 3'h6
    } ftct_mode_t;

    typedef struct packed {
        logic canh_dom;
        logic canl_dom;
        logic diff_dom;
    } ftct_bus_in_t;

    typedef struct packed {
        logic drv_h;
        logic drv_l;
        logic term_h;
        logic term_l;
        logic low_line_termination;
    } ftct_bus_out_t;

    typedef struct packed {
        ftct_mode_t       mode;
        logic [NFAIL-1:0] fail_q;
        logic [CNT_W-1:0] qual_cnt;
        logic [CNT_W-1:0] dom_cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic [CNT_W-1:0] bus_cnt;
        logic [CNT_W-1:0] gts_cnt;
        logic             tx_off;
        logic             wake_lvl;
        logic             por_flag;
        logic             wake_flag;
        logic             tx_mute;
        logic             rxd;
        logic             err_n;
        logic             vreg;
        logic             vreg_oe_n;
        logic             tx_dom;
        ftct_bus_out_t    bus;
        logic             aw_got;
        logic             w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } ftct_state_t;

endpackage : ftct_pkg

// ==== ftct_ctrl.sv ====
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ftct_ctrl
    import ftct_pkg::*;
#(
    parameter int unsigned DOM_TO_CYC      = DOM_TIMEOUT_CYC,
    parameter int unsigned REMOTE_CYC      = REMOTE_WAKE_CYC,
    parameter int unsigned FAIL_QUAL_CYC   = FAIL_QUAL_CYC_DEF,
    parameter int unsigned FAIL_RECOV_CYC  = FAIL_RECOV_CYC_DEF
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic              txd,
    input  wire logic              standby_ctrl,
    input  wire logic              mode_enable,
    input  wire logic              wake_in,
    input  wire logic              bat_por_evt,
    input  wire logic              vcc_ok,
    input  wire logic [NFAIL-1:0]  fail_raw,
    input  wire ftct_bus_in_t      bus_in,
    output var  ftct_bus_out_t     bus_out,
    output var  logic              tx_dom,
    output var  logic              rxd,
    output var  logic              err_n,
    output var  logic              regulator_inhibit_out,
    output var  logic              regulator_inhibit_oe_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready
);

    ftct_state_t      st;
    ftct_state_t      n;
    ftct_mode_t       sel;
    logic             lp;
    logic [NFAIL-1:0] raw_m;
    logic             onset;
    logic             sw;
    logic             rx_dom;
    logic             wake_evt;
    logic             wake_clr;

    always_comb begin
        n        = st;
        sel      = FT_STANDBY;
        lp       = 1'b0;
        raw_m    = '0;
        onset    = 1'b0;
        sw       = 1'b0;
        rx_dom   = 1'b0;
        wake_evt = 1'b0;
        wake_clr = 1'b0;

        // Mode pins, forced low when the logic supply is gone
        if (vcc_ok) begin
            case ({standby_ctrl, mode_enable})
                2'b11:   sel = FT_NORMAL;
                2'b10:   sel = FT_PWRON;
                2'b01:   sel = FT_GTS;
                default: sel = FT_STANDBY;
            endcase
        end

        // Mode sequencing
        n.gts_cnt = '0;
        case (st.mode)
            FT_GTS: begin
                if (sel == FT_GTS) begin
                    if (st.gts_cnt == CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
                        n.mode = FT_SLEEP;
                    end else begin
                        n.gts_cnt = st.gts_cnt + 1'b1;
                    end
                end else begin
                    n.mode = sel;
                end
            end
            FT_SLEEP: begin
                if (sel == FT_NORMAL || sel == FT_PWRON) begin
                    n.mode = sel;
                end
            end
            FT_NORMAL, FT_PWRON, FT_STANDBY: begin
                n.mode = sel;
            end
            default: begin
                n.mode = FT_STANDBY;
            end
        endcase
        lp = (n.mode != FT_NORMAL);

        // Failure qualification; low-power modes watch a subset only
        raw_m = lp ? (fail_raw & FAIL_LP_MASK) : fail_raw;
        onset = |(raw_m & ~st.fail_q);
        if (raw_m != st.fail_q) begin
            if (onset && st.qual_cnt >= CNT_W'(FAIL_QUAL_CYC - 1)) begin
                n.fail_q   = raw_m;
                n.qual_cnt = '0;
            end else if (!onset && st.qual_cnt >= CNT_W'(FAIL_RECOV_CYC - 1)) begin
                n.fail_q   = raw_m;
                n.qual_cnt = '0;
            end else begin
                n.qual_cnt = st.qual_cnt + 1'b1;
            end
        end else begin
            n.qual_cnt = '0;
        end

        // Dominant time-out on the transmit input
        if (n.mode == FT_NORMAL && !txd) begin
            if (!st.tx_off) begin
                if (st.dom_cnt == CNT_W'(DOM_TO_CYC - 1)) begin
                    n.tx_off  = 1'b1;
                    n.dom_cnt = '0;
                end else begin
                    n.dom_cnt = st.dom_cnt + 1'b1;
                end
            end
        end else begin
            n.tx_off  = 1'b0;
            n.dom_cnt = '0;
        end

        // Local wake: both edges, new level must be held
        if (wake_in != st.wake_lvl) begin
            if (st.wake_cnt == CNT_W'(WAKE_DEBOUNCE_CYC - 1)) begin
                n.wake_lvl = wake_in;
                n.wake_cnt = '0;
                wake_evt   = lp;
            end else begin
                n.wake_cnt = st.wake_cnt + 1'b1;
            end
        end else begin
            n.wake_cnt = '0;
        end

        // Remote wake: dominant on either line alone
        if (lp && (bus_in.canh_dom || bus_in.canl_dom)) begin
            if (st.bus_cnt == CNT_W'(REMOTE_CYC - 1)) begin
                wake_evt  = 1'b1;
                n.bus_cnt = '0;
            end else begin
                n.bus_cnt = st.bus_cnt + 1'b1;
            end
        end else begin
            n.bus_cnt = '0;
        end

        if (bat_por_evt) begin
            wake_evt = 1'b1;
        end

        // AXI4-Lite write channel
        if (st.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (st.awready && awvalid) begin
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
        end
        if (st.wready && wvalid) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (n.aw_got && n.w_got && !st.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            case (n.awaddr)
                REG_CTRL: begin
                    if (n.wstrb[0]) begin
                        n.tx_mute = n.wdata[CTRL_TX_MUTE];
                        wake_clr  = n.wdata[CTRL_WAKE_CLR];
                    end
                end
                REG_STATUS, REG_FAIL: begin
                    n.bresp = RESP_OKAY;
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;

        // Flags: clear first, so a set in the same cycle wins
        if (n.mode == FT_NORMAL && st.mode != FT_NORMAL) begin
            n.por_flag  = 1'b0;
            n.wake_flag = 1'b0;
        end
        if (wake_clr) begin
            n.wake_flag = 1'b0;
        end
        if (bat_por_evt) begin
            n.por_flag = 1'b1;
        end
        if (wake_evt) begin
            n.wake_flag = 1'b1;
        end

        // AXI4-Lite read channel
        if (st.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (st.arready && arvalid) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            case (araddr)
                REG_CTRL:   n.rdata = {31'h0, st.tx_mute};
                REG_STATUS: n.rdata = {24'h0, vcc_ok, st.wake_flag, st.por_flag,
                                       st.tx_off, |(st.fail_q & FAIL_SW_MASK), st.mode};
                REG_FAIL:   n.rdata = {23'h0, st.fail_q};
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;

        // Wire configuration from qualified failures
        sw                = |(n.fail_q & FAIL_SW_MASK);
        n.bus.term_h      = ~|(n.fail_q & FAIL_H_MASK);
        n.bus.term_l      = ~|(n.fail_q & FAIL_L_MASK);
        n.bus.low_line_termination = lp;
        n.tx_dom          = (n.mode == FT_NORMAL) && !txd && !n.tx_off && !n.tx_mute;
        n.bus.drv_h       = n.tx_dom && n.bus.term_h;
        n.bus.drv_l       = n.tx_dom && n.bus.term_l;
        if (!sw) begin
            rx_dom = bus_in.diff_dom;
        end else if (!n.bus.term_h) begin
            rx_dom = bus_in.canl_dom;
        end else begin
            rx_dom = bus_in.canh_dom;
        end

        // Host-side outputs per mode
        if (!vcc_ok) begin
            n.rxd   = 1'b1;
            n.err_n = 1'b1;
        end else if (n.mode == FT_NORMAL) begin
            n.rxd   = !rx_dom;
            n.err_n = ~|n.fail_q;
        end else if (n.mode == FT_PWRON) begin
            n.rxd   = !n.wake_flag;
            n.err_n = !n.por_flag;
        end else begin
            n.rxd   = !n.wake_flag;
            n.err_n = !n.wake_flag;
        end

        // Regulator inhibit floats only in sleep without a wake request
        if (n.mode == FT_SLEEP && !n.wake_flag) begin
            n.vreg      = 1'b0;
            n.vreg_oe_n = 1'b1;
        end else begin
            n.vreg      = 1'b1;
            n.vreg_oe_n = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.mode     <= FT_STANDBY;
            st.por_flag <= 1'b1;
            st.wake_flag <= 1'b1;
            st.wake_lvl <= 1'b1;
            st.rxd      <= 1'b1;
            st.err_n    <= 1'b1;
            st.vreg     <= 1'b1;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
        end else if (clk_en) begin
            st <= n;
        end
    end

    assign bus_out                = st.bus;
    assign tx_dom                 = st.tx_dom;
    assign rxd                    = st.rxd;
    assign err_n                  = st.err_n;
    assign regulator_inhibit_out  = st.vreg;
    assign regulator_inhibit_oe_n = st.vreg_oe_n;
    assign awready                = st.awready;
    assign wready                 = st.wready;
    assign bresp                  = st.bresp;
    assign bvalid                 = st.bvalid;
    assign arready                = st.arready;
    assign rdata                  = st.rdata;
    assign rresp                  = st.rresp;
    assign rvalid                 = st.rvalid;

    AST_ERR_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && vcc_ok && sel == FT_NORMAL && st.mode != FT_SLEEP && st.mode != FT_GTS
        |=> st.err_n == !(|st.fail_q))
        else $error("error output does not follow failures");

    AST_DOM_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        st.tx_off |-> !st.tx_dom && !st.bus.drv_h && !st.bus.drv_l)
        else $error("dominant drive after time-out");

    AST_DOM_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st.tx_off) |-> $past(st.dom_cnt) == CNT_W'(DOM_TO_CYC - 1))
        else $error("time-out fired at wrong count");

    AST_SLEEP_VREG: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == FT_SLEEP && !st.wake_flag |-> st.vreg_oe_n && st.bus.low_line_termination)
        else $error("inhibit not released in sleep");

    AST_STBY_VREG: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == FT_STANDBY |-> !st.vreg_oe_n && st.vreg && !st.tx_dom)
        else $error("standby inhibit not high");

    AST_PWRON_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && vcc_ok && st.mode == FT_PWRON ##1 st.mode == FT_PWRON
        |-> st.err_n == !st.por_flag && st.rxd == !st.wake_flag)
        else $error("power-on standby outputs wrong");

    AST_WAKE_VREG: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bat_por_evt |=> st.wake_flag && st.vreg && !st.vreg_oe_n)
        else $error("wake did not raise inhibit");

    AST_VCC_SAFE: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && !vcc_ok |=> st.mode != FT_NORMAL && st.mode != FT_PWRON)
        else $error("mode not forced low without supply");

    AST_QUAL_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(st.fail_q) && $past(onset) |-> $past(st.qual_cnt) >= CNT_W'(FAIL_QUAL_CYC - 1))
        else $error("failure taken before qualifying delay");

    AST_QUAL_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(st.fail_q) && !$past(onset) |-> $past(st.qual_cnt) >= CNT_W'(FAIL_RECOV_CYC - 1))
        else $error("recovery before delay");

    AST_GTS_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == FT_SLEEP && $past(st.mode) == FT_GTS
        |-> $past(st.gts_cnt) == CNT_W'(SLEEP_ENTRY_CYC - 1))
        else $error("sleep entered before hold time");

endmodule : ftct_ctrl
`default_nettype wire

// ==== ftct_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ftct_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       vcc_ok,
    input  wire logic       err_n,
    input  wire logic       auto_wake,
    input  wire logic [1:0] mode_req,
    input  wire logic       tx_req,
    output var  logic       txd,
    output var  logic       standby_ctrl,
    output var  logic       mode_enable
);
    logic [1:0] req_ff  = 2'h0;
    logic [1:0] pins_ff = 2'h0;
    logic       txd_ff  = 1'b1;

    assign standby_ctrl = pins_ff[1];
    assign mode_enable  = pins_ff[0];
    assign txd          = txd_ff;

    // Pins move only just after an edge, like a controller port
    always @(posedge aclk) begin
        req_ff <= mode_req;
        txd_ff <= aresetn ? tx_req : 1'b1;
        if (!aresetn || mode_req != req_ff) begin
            pins_ff <= mode_req;
        end else if (auto_wake && vcc_ok && !err_n && pins_ff != 2'h3) begin
            pins_ff <= 2'h3;
        end
    end
endmodule : ftct_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import ftct_pkg::*;;
    logic aclk, aresetn, clk_en, txd, standby_ctrl, mode_enable, wake_in, bat_por_evt;
    logic vcc_ok, tx_dom, rxd, err_n, vreg, vreg_oe_n, auto_wake, tx_req;
    logic [1:0] mode_req, bresp, rresp;
    logic [NFAIL-1:0] fail_raw;
    ftct_bus_in_t bus_in;
    ftct_bus_out_t bus_out;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    ftct_ctrl #(.DOM_TO_CYC(50), .REMOTE_CYC(20), .FAIL_QUAL_CYC(8), .FAIL_RECOV_CYC(12)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .txd(txd),
        .standby_ctrl(standby_ctrl), .mode_enable(mode_enable), .wake_in(wake_in),
        .bat_por_evt(bat_por_evt), .vcc_ok(vcc_ok), .fail_raw(fail_raw), .bus_in(bus_in),
        .bus_out(bus_out), .tx_dom(tx_dom), .rxd(rxd), .err_n(err_n),
        .regulator_inhibit_out(vreg), .regulator_inhibit_oe_n(vreg_oe_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    ftct_host_model host_u (
        .aclk(aclk), .aresetn(aresetn), .vcc_ok(vcc_ok), .err_n(err_n),
        .auto_wake(auto_wake), .mode_req(mode_req), .tx_req(tx_req), .txd(txd),
        .standby_ctrl(standby_ctrl), .mode_enable(mode_enable));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask : chkw

    task automatic wait_c(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_c

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chkw("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chkw("rdata", ed, rdata);
        chkw("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : axi_rd

    initial begin
        {aresetn, bat_por_evt, auto_wake, fail_raw, bus_in, mode_req} = '0;
        // Wake pin idles at the level the detector holds after reset
        {clk_en, vcc_ok, tx_req, wake_in} = 4'hf;
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wait_c(5);
        chk1("err_n", 1'b0, err_n);
        chk1("rxd", 1'b0, rxd);
        chk1("vreg", 1'b1, vreg);
        chk1("vreg_oe_n", 1'b0, vreg_oe_n);
        chk1("bias", 1'b1, bus_out.low_line_termination);
        axi_rd(REG_STATUS, 32'he2, RESP_OKAY);
        axi_rd(4'hc, 32'h0, RESP_SLVERR);
        axi_wr(4'hc, 32'h1, 4'hf, RESP_SLVERR);
        axi_wr(REG_STATUS, 32'hff, 4'hf, RESP_OKAY);
        axi_rd(REG_STATUS, 32'he2, RESP_OKAY);
        fail_raw <= 9'h101;
        wait_c(20);
        axi_rd(REG_FAIL, 32'h100, RESP_OKAY);
        fail_raw <= '0;
        wait_c(30);
        mode_req <= 2'h2;
        wait_c(5);
        chk1("err_n", 1'b0, err_n);
        axi_wr(REG_CTRL, 32'h2, 4'h1, RESP_OKAY);
        wait_c(3);
        chk1("rxd", 1'b1, rxd);
        chk1("err_n", 1'b0, err_n);
        axi_rd(REG_STATUS, 32'ha6, RESP_OKAY);
        mode_req <= 2'h3;
        wait_c(5);
        axi_rd(REG_STATUS, 32'h80, RESP_OKAY);
        chk1("err_n", 1'b1, err_n);
        bus_in.diff_dom <= 1'b1;
        wait_c(3);
        chk1("rxd", 1'b0, rxd);
        bus_in.diff_dom <= 1'b0;
        axi_wr(REG_CTRL, 32'h1, 4'h0, RESP_OKAY);
        axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1, 4'h1, RESP_OKAY);
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        tx_req <= 1'b0;
        wait_c(5);
        chk1("tx_dom", 1'b0, tx_dom);
        tx_req <= 1'b1;
        axi_wr(REG_CTRL, 32'h0, 4'h1, RESP_OKAY);
        tx_req <= 1'b0;
        wait_c(4);
        chk1("tx_dom", 1'b1, tx_dom);
        wait_c(40);
        chk1("tx_dom", 1'b1, tx_dom);
        wait_c(20);
        chk1("tx_dom", 1'b0, tx_dom);
        axi_rd(REG_STATUS, 32'h90, RESP_OKAY);
        tx_req <= 1'b1;
        wait_c(4);
        axi_rd(REG_STATUS, 32'h80, RESP_OKAY);
        for (int i = 0; i < NFAIL; i++) begin
            fail_raw <= 9'(1 << i);
            wait_c(4);
            chk1("err_n", 1'b1, err_n);
            wait_c(16);
            chk1("err_n", 1'b0, err_n);
            chk1("term_h", ~FAIL_H_MASK[i], bus_out.term_h);
            chk1("term_l", ~FAIL_L_MASK[i], bus_out.term_l);
            axi_rd(REG_FAIL, 32'(1 << i), RESP_OKAY);
            axi_rd(REG_STATUS, 32'h80 | ({31'h0, FAIL_SW_MASK[i]} << 3), RESP_OKAY);
            tx_req <= 1'b0;
            wait_c(4);
            chk1("drv_h", ~FAIL_H_MASK[i], bus_out.drv_h);
            chk1("drv_l", ~FAIL_L_MASK[i], bus_out.drv_l);
            tx_req <= 1'b1;
            fail_raw <= '0;
            wait_c(6);
            chk1("err_n", 1'b0, err_n);
            wait_c(20);
            chk1("err_n", 1'b1, err_n);
            chk1("term_l", 1'b1, bus_out.term_l);
        end
        fail_raw <= 9'h001;
        wait_c(4);
        fail_raw <= '0;
        wait_c(20);
        chk1("err_n", 1'b1, err_n);
        vcc_ok <= 1'b0;
        wait_c(5);
        axi_rd(REG_STATUS, 32'h02, RESP_OKAY);
        chk1("rxd", 1'b1, rxd);
        chk1("err_n", 1'b1, err_n);
        vcc_ok <= 1'b1;
        wait_c(5);
        axi_rd(REG_STATUS, 32'h80, RESP_OKAY);
        mode_req <= 2'h1;
        wait_c(900);
        axi_rd(REG_STATUS, 32'h81, RESP_OKAY);
        chk1("vreg_oe_n", 1'b0, vreg_oe_n);
        chk1("vreg", 1'b1, vreg);
        mode_req <= 2'h0;
        wait_c(5);
        axi_rd(REG_STATUS, 32'h82, RESP_OKAY);
        mode_req <= 2'h1;
        wait_c(1100);
        axi_rd(REG_STATUS, 32'h83, RESP_OKAY);
        chk1("vreg_oe_n", 1'b1, vreg_oe_n);
        chk1("bias", 1'b1, bus_out.low_line_termination);
        wake_in <= 1'b0;
        wait_c(500);
        wake_in <= 1'b1;
        wait_c(10);
        chk1("vreg_oe_n", 1'b1, vreg_oe_n);
        wake_in <= 1'b0;
        wait_c(1500);
        chk1("vreg_oe_n", 1'b0, vreg_oe_n);
        chk1("vreg", 1'b1, vreg);
        chk1("rxd", 1'b0, rxd);
        chk1("err_n", 1'b0, err_n);
        axi_rd(REG_STATUS, 32'hc3, RESP_OKAY);
        auto_wake <= 1'b1;
        wait_c(10);
        axi_rd(REG_STATUS, 32'h80, RESP_OKAY);
        auto_wake <= 1'b0;
        mode_req <= 2'h3;
        wait_c(2);
        mode_req <= 2'h1;
        wait_c(1100);
        chk1("vreg_oe_n", 1'b1, vreg_oe_n);
        bus_in.canl_dom <= 1'b1;
        wait_c(10);
        bus_in.canl_dom <= 1'b0;
        wait_c(3);
        chk1("vreg_oe_n", 1'b1, vreg_oe_n);
        bus_in.canl_dom <= 1'b1;
        wait_c(30);
        bus_in.canl_dom <= 1'b0;
        wait_c(3);
        chk1("vreg_oe_n", 1'b0, vreg_oe_n);
        chk1("rxd", 1'b0, rxd);
        mode_req <= 2'h3;
        wait_c(5);
        mode_req <= 2'h0;
        wait_c(5);
        bat_por_evt <= 1'b1;
        wait_c(1);
        bat_por_evt <= 1'b0;
        wait_c(3);
        axi_rd(REG_STATUS, 32'he2, RESP_OKAY);
        // Frozen clock enable must hold standby even when normal is selected
        clk_en <= 1'b0;
        mode_req <= 2'h3;
        wait_c(6);
        chk1("rxd", 1'b0, rxd);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
